// [logic/fbe_pkg.sv]
// Shared constants, types and register map of the frame bit-stream encoder
package fbe_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_PS  = 25000;
   localparam int unsigned BIT_TIME_PS    = 100000;
   // Longest whole count of clocks within one bit, at least one
   localparam int unsigned BIT_CYCLES     =
      (BIT_TIME_PS / CLK_PERIOD_PS) < 1 ? 1 : (BIT_TIME_PS / CLK_PERIOD_PS);
   localparam logic [15:0] BIT_LEN_RESET  = 16'(BIT_CYCLES);
   localparam logic [15:0] TSS_LEN_RESET  = 16'h0005;
   localparam int unsigned CHANNELS       = 2;
   localparam int unsigned FIFO_DEPTH     = 16;
   localparam int unsigned BYTE_BITS      = 8;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_BIT_LEN    = 8'h04;
   localparam logic [7:0]  REG_TSS_LEN    = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0c;

   localparam int unsigned CTRL_RUN_POS   = 0;
   localparam int unsigned CTRL_SINGLE_POS = 1;
   localparam int unsigned CTRL_SEL_B_POS = 2;
   localparam logic [31:0] CTRL_MASK      = 32'h0000_0007;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] LEN_MASK       = 32'h0000_ffff;
   localparam int unsigned STAT_BUSY_POS  = 0;
   localparam int unsigned STAT_FIFO_POS  = 4;

   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE, ST_TSS, ST_FSS, ST_BSS_H, ST_BSS_L, ST_DATA,
      ST_FES_L, ST_FES_H, ST_DTS_LOW, ST_DTS_HIGH
   } fbe_state_type;

   typedef struct packed {
      logic       tx_data_line;
      logic       tx_enable_line;
   } fbe_pins_type;

   typedef struct packed {
      logic       tx_req;
      logic       dynamic;
      logic       stop_req;
   } fbe_mac_type;

   typedef struct packed {
      logic       decoding_halted;
      logic       frame_sent;
      logic       dts_start;
      logic       decoding_started;
   } fbe_event_type;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } fbe_byte_type;

endpackage : fbe_pkg

// [logic/fbe_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides and a synchronous clear
`timescale 1ns/1ps
module fbe_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             clear,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign out_data = mem_r[rd_ptr_r];

   always_comb
   begin
      count_nxt = count_r;
      if (push && !pop)
         count_nxt = count_r + 1'b1;
      else if (pop && !push)
         count_nxt = count_r - 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear)
      begin
         wr_ptr_r  <= '0;
         rd_ptr_r  <= '0;
         count_r   <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
         count_r   <= count_nxt;
         in_ready  <= (count_nxt != FULL_CNT);
         out_valid <= (count_nxt != '0);
      end
   end
endmodule : fbe_fifo

// [logic/fbe_encoder.sv]
// Two-channel frame bit-stream encoder with AXI4-Lite control registers
`timescale 1ns/1ps
module fbe_encoder #(
   parameter int unsigned FIFO_DEPTH = fbe_pkg::FIFO_DEPTH
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   output      logic [1:0]             s_axi_bresp,
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Frame bytes per channel
   input  wire logic [1:0]             byte_valid,
   input  wire fbe_pkg::fbe_byte_type [1:0] byte_in,
   output      logic [1:0]             byte_ready,
   // Media access requests and encoder events per channel
   input  wire fbe_pkg::fbe_mac_type [1:0]  mac_req,
   output      fbe_pkg::fbe_event_type [1:0] enc_event,
   // Bus driver pins per channel
   output      fbe_pkg::fbe_pins_type [1:0] bd_pins
);
   import fbe_pkg::*;

   // ****************************************
   // Register file
   // ****************************************
   logic [31:0] ctrl_r;
   logic [31:0] bit_len_r;
   logic [31:0] tss_len_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic [1:0]  busy;
   logic [1:0]  fifo_has;
   logic [1:0]  chan_on;
   logic [15:0] bit_len;
   logic [15:0] tss_len;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
      return res;
   endfunction : merge

   // Address and data may arrive in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_r      <= s_axi_awaddr;
            aw_have_r     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            w_have_r     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_have_r && w_have_r)
         begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r       <= CTRL_RESET;
         bit_len_r    <= 32'(BIT_LEN_RESET);
         tss_len_r    <= 32'(TSS_LEN_RESET);
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (aw_have_r && w_have_r)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            if (awaddr_r == REG_CTRL)
               ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & CTRL_MASK;
            else if (awaddr_r == REG_BIT_LEN)
               bit_len_r <= merge(bit_len_r, wdata_r, wstrb_r) & LEN_MASK;
            else if (awaddr_r == REG_TSS_LEN)
               tss_len_r <= merge(tss_len_r, wdata_r, wstrb_r) & LEN_MASK;
            else if (awaddr_r != REG_STATUS)
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
         if (s_axi_araddr == REG_CTRL)
            s_axi_rdata <= ctrl_r;
         else if (s_axi_araddr == REG_BIT_LEN)
            s_axi_rdata <= bit_len_r;
         else if (s_axi_araddr == REG_TSS_LEN)
            s_axi_rdata <= tss_len_r;
         else if (s_axi_araddr == REG_STATUS)
         begin
            s_axi_rdata[STAT_BUSY_POS +: 2] <= busy;
            s_axi_rdata[STAT_FIFO_POS +: 2] <= fifo_has;
         end
         else
            s_axi_rresp <= RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   assign bit_len = (bit_len_r[15:0] == '0) ? 16'h0001 : bit_len_r[15:0];
   assign tss_len = (tss_len_r[15:0] == '0) ? 16'h0001 : tss_len_r[15:0];

   // single mode keeps only selected channel
   assign chan_on[0] = ctrl_r[CTRL_RUN_POS] &
                       (!ctrl_r[CTRL_SINGLE_POS] || !ctrl_r[CTRL_SEL_B_POS]);
   assign chan_on[1] = ctrl_r[CTRL_RUN_POS] &
                       (!ctrl_r[CTRL_SINGLE_POS] || ctrl_r[CTRL_SEL_B_POS]);

   // ****************************************
   // Channel encoders
   // ****************************************
   fbe_state_type state_r   [CHANNELS];
   logic [15:0]   bit_cnt_r [CHANNELS];
   logic [15:0]   tss_cnt_r [CHANNELS];
   logic [2:0]    bit_idx_r [CHANNELS];
   logic [7:0]    shift_r   [CHANNELS];
   logic          last_r    [CHANNELS];
   logic          dyn_r     [CHANNELS];
   logic          min_done_r[CHANNELS];
   logic          stop_pend_r[CHANNELS];
   logic          tick      [CHANNELS];
   logic          fetch     [CHANNELS];
   logic          pop       [CHANNELS];
   logic          f_valid   [CHANNELS];
   fbe_byte_type  f_data    [CHANNELS];

   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_chan
      fbe_fifo #(
         .WIDTH ($bits(fbe_byte_type)),
         .DEPTH (FIFO_DEPTH)
      ) u_fifo (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .clear     (!chan_on[ch]),
         .in_valid  (byte_valid[ch]),
         .in_data   (byte_in[ch]),
         .in_ready  (byte_ready[ch]),
         .out_valid (f_valid[ch]),
         .out_data  (f_data[ch]),
         .out_ready (pop[ch])
      );

      // advance when bit count completes, except leaving ST_IDLE on tx_req and ST_DTS_LOW on stop_req
      assign tick[ch]  = (bit_cnt_r[ch] == bit_len - 16'h0001);
      assign fetch[ch] = tick[ch] &&
                         ((state_r[ch] == ST_FSS) ||
                          (state_r[ch] == ST_DATA && bit_idx_r[ch] == 3'h7
                           && !last_r[ch]));
      assign pop[ch]   = fetch[ch] & f_valid[ch];
      assign busy[ch]     = (state_r[ch] != ST_IDLE);
      assign fifo_has[ch] = f_valid[ch];

      always_ff @(posedge aclk)
      begin
         if (!aresetn || !chan_on[ch])
         begin
            state_r[ch]      <= ST_IDLE;
            bit_cnt_r[ch]    <= '0;
            tss_cnt_r[ch]    <= '0;
            bit_idx_r[ch]    <= '0;
            shift_r[ch]      <= '0;
            last_r[ch]       <= 1'b0;
            dyn_r[ch]        <= 1'b0;
            min_done_r[ch]   <= 1'b0;
            stop_pend_r[ch]  <= 1'b0;
            bd_pins[ch]      <= '{tx_data_line: 1'b1, tx_enable_line: 1'b1};
            enc_event[ch]    <= '0;
         end
         else
         begin
            enc_event[ch] <= '0;
            bit_cnt_r[ch] <= tick[ch] ? '0 : bit_cnt_r[ch] + 16'h0001;
            // line changes at bit boundaries, except on tx_req in ST_IDLE and on stop_req in ST_DTS_LOW
            case (state_r[ch])
               ST_IDLE:
                  if (mac_req[ch].tx_req)
                  begin
                     enc_event[ch].decoding_halted <= 1'b1;
                     state_r[ch]     <= ST_TSS;
                     bit_cnt_r[ch]   <= '0;
                     tss_cnt_r[ch]   <= '0;
                     dyn_r[ch]       <= mac_req[ch].dynamic;
                     last_r[ch]      <= 1'b0;
                     bd_pins[ch]     <= '{tx_data_line: 1'b0,
                                          tx_enable_line: 1'b0};
                  end
               ST_TSS:
                  if (tick[ch])
                  begin
                     if (tss_cnt_r[ch] == tss_len - 16'h0001)
                     begin
                        state_r[ch]              <= ST_FSS;
                        bd_pins[ch].tx_data_line <= 1'b1;
                     end
                     else
                        tss_cnt_r[ch] <= tss_cnt_r[ch] + 16'h0001;
                  end
               ST_FSS, ST_DATA:
                  if (fetch[ch] && f_valid[ch])
                  begin
                     shift_r[ch]              <= f_data[ch].data;
                     last_r[ch]               <= f_data[ch].last;
                     state_r[ch]              <= ST_BSS_H;
                     bd_pins[ch].tx_data_line <= 1'b1;
                  end
                  else if (fetch[ch] || (tick[ch] && state_r[ch] == ST_DATA
                           && bit_idx_r[ch] == 3'h7))
                  begin
                     state_r[ch]              <= ST_FES_L;
                     bd_pins[ch].tx_data_line <= 1'b0;
                  end
                  else if (tick[ch] && state_r[ch] == ST_DATA)
                  begin
                     bit_idx_r[ch]            <= bit_idx_r[ch] + 3'h1;
                     shift_r[ch]              <= {shift_r[ch][6:0], 1'b0};
                     bd_pins[ch].tx_data_line <= shift_r[ch][6];
                  end
               ST_BSS_H:
                  if (tick[ch])
                  begin
                     state_r[ch]              <= ST_BSS_L;
                     bd_pins[ch].tx_data_line <= 1'b0;
                  end
               ST_BSS_L:
                  if (tick[ch])
                  begin
                     state_r[ch]              <= ST_DATA;
                     bit_idx_r[ch]            <= '0;
                     bd_pins[ch].tx_data_line <= shift_r[ch][7];
                  end
               ST_FES_L:
                  if (tick[ch])
                  begin
                     state_r[ch]              <= ST_FES_H;
                     bd_pins[ch].tx_data_line <= 1'b1;
                  end
               ST_FES_H:
                  if (tick[ch])
                  begin
                     enc_event[ch].frame_sent <= 1'b1;
                     if (dyn_r[ch])
                     begin
                        state_r[ch]              <= ST_DTS_LOW;
                        min_done_r[ch]           <= 1'b0;
                        stop_pend_r[ch]          <= 1'b0;
                        enc_event[ch].dts_start  <= 1'b1;
                        bd_pins[ch].tx_data_line <= 1'b0;
                     end
                     else
                     begin
                        state_r[ch]                    <= ST_IDLE;
                        enc_event[ch].decoding_started <= 1'b1;
                        bd_pins[ch].tx_enable_line     <= 1'b1;
                     end
                  end
               ST_DTS_LOW:
               begin
                  if (mac_req[ch].stop_req)
                     stop_pend_r[ch] <= 1'b1;
                  if (tick[ch])
                     min_done_r[ch] <= 1'b1;
                  if ((min_done_r[ch] || tick[ch]) &&
                      (stop_pend_r[ch] || mac_req[ch].stop_req))
                  begin
                     // data high, enable one bit later
                     state_r[ch]              <= ST_DTS_HIGH;
                     bit_cnt_r[ch]            <= '0;
                     bd_pins[ch].tx_data_line <= 1'b1;
                  end
               end
               ST_DTS_HIGH:
                  if (tick[ch])
                  begin
                     state_r[ch]                    <= ST_IDLE;
                     enc_event[ch].decoding_started <= 1'b1;
                     bd_pins[ch].tx_enable_line     <= 1'b1;
                  end
               default:
                  state_r[ch] <= ST_IDLE;
            endcase
         end
      end
   end : g_chan

endmodule : fbe_encoder

// [verification/fbe_encoder_asserts.sv]
// Timing checks on the encoder's channel A pins, events and read channel
`timescale 1ns/1ps
module fbe_encoder_asserts (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic                         s_axi_rvalid,
   input wire fbe_pkg::fbe_event_type [1:0] enc_event,
   input wire fbe_pkg::fbe_pins_type [1:0]  bd_pins
);
   import fbe_pkg::*;
   logic en0;
   logic d0;
   assign en0 = bd_pins[0].tx_enable_line;
   assign d0  = bd_pins[0].tx_data_line;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_dts_low;
      !d0 [*4];
   endsequence
   a_idle_high: assert property (en0 |-> d0)
      else $error("data line low while enable idle");
   a_start_low: assert property ($fell(en0) |-> !d0 [*8])
      else $error("start sequence not low");
   a_halt_event: assert property ($fell(en0) |->
      enc_event[0].decoding_halted)
      else $error("no halt event at frame start");
   a_bit_hold: assert property ($changed(d0) && !en0 |=>
      $stable(d0) [*3])
      else $error("data changed inside a bit");
   a_end_tail: assert property ($rose(en0) |->
      $past(d0) && $past(d0, 4) && !$past(d0, 5))
      else $error("wrong tail before enable release");
   a_end_events: assert property ($rose(en0) |->
      enc_event[0].decoding_started)
      else $error("no restart event at enable release");
   a_dts_low: assert property (
      enc_event[0].dts_start |-> enc_event[0].frame_sent ##0 s_dts_low)
      else $error("trailing low too short or late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle later");
endmodule : fbe_encoder_asserts

// [verification/fbe_bd_model.sv]
// Bus driver stand-in that samples each sent bit in its middle
`timescale 1ns/1ps
module fbe_bd_model #(
   parameter int unsigned BIT_LEN = 4
) (
   input  wire fbe_pkg::fbe_pins_type pins,
   input  wire logic                  aclk,
   output      logic [63:0]           bits,
   output      logic [7:0]            nbits
);
   import fbe_pkg::*;
   logic        en_prev_r;
   logic [15:0] phase_r;
   logic [15:0] ph;
   // Phase restarts at the enable's falling edge
   assign ph = en_prev_r ? 16'h0 : phase_r;
   always_ff @(posedge aclk)
   begin
      en_prev_r <= pins.tx_enable_line;
      if (!pins.tx_enable_line)
      begin
         phase_r <= (ph == 16'(BIT_LEN - 1)) ? 16'h0 : ph + 16'h1;
         if (ph == 16'(BIT_LEN / 2))
         begin
            bits  <= {bits[62:0], pins.tx_data_line};
            nbits <= nbits + 8'h1;
         end
      end
      if (!pins.tx_enable_line && en_prev_r)
         nbits <= 8'h0;
   end
endmodule : fbe_bd_model

// [verification/testbench.sv]
// Self-checking bench of the two-channel frame encoder
`timescale 1ns/1ps
module testbench;
   import fbe_pkg::*;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic [1:0]  resp;
   } fbe_row_type;
   logic                aclk, aresetn;
   logic [7:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                s_axi_rready;
   logic [1:0]          byte_valid, byte_ready;
   fbe_byte_type [1:0]  byte_in;
   fbe_mac_type [1:0]   mac_req;
   fbe_event_type [1:0] enc_event;
   fbe_pins_type [1:0]  bd_pins;
   logic [63:0]         bits_a, bits_b;
   logic [7:0]          nbits_a, nbits_b;
   int                  error_cnt = 0;
   int                  n_checks = 0;
   fbe_row_type         rows [9] = '{
      '{1'b0, REG_CTRL, 32'h0, CTRL_RESET, RESP_OKAY},
      '{1'b0, REG_BIT_LEN, 32'h0, 32'h4, RESP_OKAY},
      '{1'b0, REG_TSS_LEN, 32'h0, 32'h5, RESP_OKAY},
      '{1'b0, REG_STATUS, 32'h0, 32'h0, RESP_OKAY},
      '{1'b1, REG_STATUS, 32'hffff_ffff, 32'h0, RESP_OKAY},
      '{1'b1, REG_TSS_LEN, 32'habcd_0007, 32'h7, RESP_OKAY},
      '{1'b1, REG_TSS_LEN, 32'h0000_0005, 32'h5, RESP_OKAY},
      '{1'b1, REG_CTRL, 32'hffff_fff1, 32'h1, RESP_OKAY},
      '{1'b1, 8'h14, 32'h1, 32'h0, RESP_SLVERR}};

   fbe_encoder fbe_encoder_inst (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .byte_valid, .byte_in, .byte_ready, .mac_req, .enc_event, .bd_pins);
   fbe_bd_model fbe_bd_model_a (.pins(bd_pins[0]), .aclk(aclk),
      .bits(bits_a), .nbits(nbits_a));
   fbe_bd_model fbe_bd_model_b (.pins(bd_pins[1]), .aclk(aclk),
      .bits(bits_b), .nbits(nbits_b));

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   task end_test(input string nm);
      $display("test %s done, mismatches so far %0d", nm, error_cnt);
   endtask : end_test

   task tally_and_finish;
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task axi_write(input logic [7:0] a, input logic [31:0] d,
                  output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
      r = s_axi_bresp;
   endtask : axi_write

   task axi_read(input logic [7:0] a, output logic [31:0] d,
                 output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axi_read

   task push(input int ch, input logic [7:0] d, input logic l);
      byte_in[ch]    <= {l, d};
      byte_valid[ch] <= 1'b1;
      do @(posedge aclk); while (!byte_ready[ch]);
   endtask : push

   task send(input int ch, input logic dyn);
      byte_valid[ch]      <= 1'b0;
      mac_req[ch].dynamic <= dyn;
      mac_req[ch].tx_req  <= 1'b1;
      @(posedge aclk);
      mac_req[ch].tx_req  <= 1'b0;
   endtask : send

   task wait_done(input int ch, output int n);
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end while (!enc_event[ch].decoding_started && n < 2000);
   endtask : wait_done

   // Stop request comes dly cycles after the trailing start is seen
   task dyn_frame(input int dly, output int n_low, output int n_en);
      push(0, 8'h55, 1'b1);
      send(0, 1'b1);
      n_low = 0;
      do
      begin
         @(posedge aclk);
         n_low++;
      end while (!enc_event[0].dts_start && n_low < 500);
      n_low = 0;
      do
      begin
         if (n_low == dly) mac_req[0].stop_req <= 1'b1;
         @(posedge aclk);
         n_low++;
         if (n_low == dly + 1) mac_req[0].stop_req <= 1'b0;
      end while (!bd_pins[0].tx_data_line && n_low < 40);
      wait_done(0, n_en);
   endtask : dyn_frame

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      int n;
      int m;
      logic [31:0] d;
      logic [1:0] r;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      byte_valid = '0;
      byte_in = '0;
      mac_req = '0;
      repeat (6) @(posedge aclk);
      chk("reset pins", 64'hf, 64'(bd_pins));
      chk("reset byte ready", 64'h3, 64'(byte_ready));
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rows[i])
      begin
         if (rows[i].wr)
         begin
            axi_write(rows[i].addr, rows[i].wdata, r);
            chk("write resp", 64'(rows[i].resp), 64'(r));
         end
         axi_read(rows[i].addr, d, r);
         chk("read data", 64'(rows[i].exp), 64'(d));
         chk("read resp", 64'(rows[i].resp), 64'(r));
      end
      end_test("registers");
      for (int i = 0; i < 16; i++)
         push(0, (i == 15) ? 8'h0f : 8'(i), i == 15);
      @(posedge aclk);
      chk("full fifo ready", 64'h0, 64'(byte_ready[0]));
      send(0, 1'b0);
      wait_done(0, n);
      chk("bit count A", 64'd168, 64'(nbits_a));
      chk("tail bits A", 64'b10_00001111_01, 64'(bits_a[11:0]));
      chk("drained fifo ready", 64'h1, 64'(byte_ready[0]));
      end_test("static frame A");
      push(1, 8'h3c, 1'b0);
      push(1, 8'h81, 1'b1);
      send(1, 1'b0);
      wait_done(1, n);
      chk("bit count B", 64'd28, 64'(nbits_b));
      chk("bits B",
         64'b00000_1_10_00111100_10_10000001_01, 64'(bits_b[27:0]));
      end_test("static frame B");
      dyn_frame(0, n, m);
      chk("early stop low", 64'd4, 64'(n));
      chk("enable delay", 64'd4, 64'(m));
      dyn_frame(6, n, m);
      chk("late stop low", 64'd8, 64'(n));
      chk("enable delay", 64'd4, 64'(m));
      end_test("dynamic frames");
      axi_write(REG_CTRL, 32'h7, r);
      push(1, 8'h99, 1'b1);
      send(0, 1'b0);
      send(1, 1'b0);
      repeat (8) @(posedge aclk);
      chk("unused pins", 64'h3, 64'(bd_pins[0]));
      chk("active enable", 64'h0, 64'(bd_pins[1].tx_enable_line));
      axi_write(REG_CTRL, 32'h0, r);
      @(posedge aclk);
      chk("stopped pins", 64'hf, 64'(bd_pins));
      end_test("single channel and stop");
      tally_and_finish();
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      tally_and_finish();
   end
endmodule : testbench

bind fbe_encoder fbe_encoder_asserts fbe_encoder_asserts_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .enc_event(enc_event), .bd_pins(bd_pins));
